// [aux_monitor.sv]
// Auxiliary converter control, temperature readout and battery monitor.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Go flag reads busy, self-clears at end.
// - Conversion completes within 350 microseconds.
// - Result held in read-only result register.
// - Input and reference selected by config fields.
// - Result is an 8-bit unsigned code.
// - Bridge amplifier gain from config field.
// - Supply-dependent offset from sensor offset field.
// - Sensor powered only when selected or on bus.
// - Range field scales temperature; relative test mode.
// - Digital offset added to result when enabled.
// - Analog trim applied to sensor when enabled.
// - Writable 5-bit battery threshold, resets to 14h.
// - Interrupt output asserts low when enabled.
// - Four consecutive low readings raise the event.
// - Battery sensed every second for 250 microseconds.
// - Battery level 5-bit, upper bits read zero.
// - Level code steps 50 mV from 1.7 V.
// - Sleep monitoring starts the RC oscillator.
module aux_monitor
  import aux_monitor_pkg::*;
#(
  parameter int unsigned CONV_CYC       = aux_monitor_pkg::CONV_CYCLES,
  parameter int unsigned BAT_PERIOD_CYC = aux_monitor_pkg::BAT_PERIOD_CYCLES,
  parameter int unsigned BAT_ON_CYC     = aux_monitor_pkg::BAT_ON_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Register access port.
  input  wire logic [6:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_wr_data,
  input  wire logic       reg_rd_en,
  output logic      [7:0] reg_rd_data,
  // General purpose converter.
  input  wire logic [7:0] conv_raw_code,
  output logic            conv_active,
  output logic      [2:0] conv_input_sel,
  output logic      [1:0] conv_ref_sel,
  output logic      [1:0] bridge_amp_gain,
  output logic      [3:0] supply_offset_trim,
  // Temperature sensor.
  input  wire logic       temp_on_test_bus,
  input  wire logic       relative_temp_mode,
  output logic            temp_sensor_power,
  output logic      [1:0] thermal_range_sel,
  output logic            temp_relative_out,
  output logic            analog_trim_en,
  output logic      [1:0] analog_temp_trim,
  output logic      [1:0] bandgap_trim,
  // Battery monitor.
  input  wire logic       battery_monitor_en,
  input  wire logic       sleep_mode,
  input  wire logic       battery_irq_en,
  input  wire logic       battery_irq_ack,
  input  wire logic [4:0] battery_raw_code,
  output logic            battery_sense_power,
  output logic            rc_osc_en,
  output logic            battery_low_event,
  output logic            interrupt_out_n
);

  import aux_monitor_pkg::*;

  // ===========================================================================
  // Declarations
  logic [2:0] input_sel_q;
  logic [1:0] ref_sel_q;
  logic [1:0] gain_q;
  logic [3:0] soffs_q;
  logic [7:0] tsc_q;
  logic [7:0] tvoffs_q;
  logic [4:0] threshold_q;
  logic [4:0] level_q;
  logic [7:0] result_q;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic       pend_q;
  logic [31:0] period_q;
  logic       conv_start;
  logic       conv_busy;
  logic       conv_done;
  logic [8:0] offset_sum;
  logic [7:0] result_d;
  logic       bat_tick;
  logic       bat_busy;
  logic       bat_done;
  logic       bat_low;
  logic       bat_trigger;
  logic       bat_reading;
  logic       wr_cfg;
  logic       wr_soffs;
  logic       wr_tsc;
  logic       wr_tvoffs;
  logic       wr_thresh;

  // ===========================================================================
  // Write decode
  // Writes to unknown addresses select no register and are ignored.
  always_comb begin
    wr_cfg    = 1'b0;
    wr_soffs  = 1'b0;
    wr_tsc    = 1'b0;
    wr_tvoffs = 1'b0;
    wr_thresh = 1'b0;
    if (!reg_wr_en) begin
      wr_cfg = 1'b0;
    end else if (reg_addr == ADDR_CONV_CONFIG) begin
      wr_cfg = 1'b1;
    end else if (reg_addr == ADDR_SENSOR_OFFSET) begin
      wr_soffs = 1'b1;
    end else if (reg_addr == ADDR_THERMAL_CTRL) begin
      wr_tsc = 1'b1;
    end else if (reg_addr == ADDR_THERMAL_OFFS) begin
      wr_tvoffs = 1'b1;
    end else if (reg_addr == ADDR_BAT_THRESHOLD) begin
      wr_thresh = 1'b1;
    end
  end

  // ===========================================================================
  // Conversion configuration fields
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      input_sel_q <= CFG_RESET[CFG_INPUT_LSB +: 3];
      ref_sel_q   <= CFG_RESET[CFG_REF_LSB +: 2];
      gain_q      <= CFG_RESET[CFG_GAIN_LSB +: 2];
    end else if (wr_cfg) begin
      input_sel_q <= reg_wr_data[CFG_INPUT_LSB +: 3];
      ref_sel_q   <= reg_wr_data[CFG_REF_LSB +: 2];
      gain_q      <= reg_wr_data[CFG_GAIN_LSB +: 2];
    end
  end

  // Go bit written as one starts a conversion; the timer drops it if busy.
  assign conv_start = wr_cfg && reg_wr_data[CFG_GO_BIT];

  // ===========================================================================
  // Sensor offset and temperature control
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      soffs_q <= SENSOR_OFFS_RESET;
    end else if (wr_soffs) begin
      soffs_q <= reg_wr_data[3:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tsc_q <= THERMAL_CTRL_RESET;
    end else if (wr_tsc) begin
      tsc_q <= reg_wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tvoffs_q <= THERMAL_OFFS_RESET;
    end else if (wr_tvoffs) begin
      tvoffs_q <= reg_wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      threshold_q <= BAT_THRESH_RESET;
    end else if (wr_thresh) begin
      threshold_q <= reg_wr_data[4:0];
    end
  end

  // ===========================================================================
  // Conversion timing
  // Both timers count every clock, so host access timing never stretches them.
  // Config fields may change mid-conversion; only a second go is refused.
  duration_timer #(
    .CYCLES (CONV_CYC)
  ) u_conv_timer (
    .core_clk (core_clk),
    .nrst     (nrst),
    .start    (conv_start),
    .busy     (conv_busy),
    .done     (conv_done)
  );

  // The digital offset saturates so a hot reading never wraps to cold.
  always_comb begin
    offset_sum = {1'b0, conv_raw_code} + {1'b0, tvoffs_q};
    result_d   = conv_raw_code;
    if (tsc_q[TSC_DIGOFFS_BIT]) begin
      if (offset_sum[8]) begin
        result_d = RESULT_MAX;
      end else begin
        result_d = offset_sum[7:0];
      end
    end
  end

  // The result is captured on the same edge at which busy drops.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      result_q <= 8'h00;
    end else if (conv_done) begin
      result_q <= result_d;
    end
  end

  assign conv_active        = conv_busy;
  assign conv_input_sel     = input_sel_q;
  assign conv_ref_sel       = ref_sel_q;
  assign bridge_amp_gain    = gain_q;
  assign supply_offset_trim = soffs_q;

  // ===========================================================================
  // Temperature sensor controls
  // The sensor is powered only while something can read it.
  assign temp_sensor_power = (input_sel_q == INPUT_TEMP_SENSOR)
                             || temp_on_test_bus;
  assign thermal_range_sel = tsc_q[TSC_RANGE_LSB +: 2];
  assign temp_relative_out = relative_temp_mode;
  assign analog_trim_en    = tsc_q[TSC_ATRIM_BIT];
  // Trim bits reach the sensor only while the analog trim is enabled.
  for (genvar b = 0; b < 2; b++) begin : g_trim
    assign analog_temp_trim[b] = tsc_q[TSC_ATRIM_BIT]
                                 && tsc_q[TSC_TRIM_LSB + b];
  end
  assign bandgap_trim      = tsc_q[TSC_BGTRIM_LSB +: 2];

  // ===========================================================================
  // Battery measurement period
  // The counter restarts while the monitor is off, so the first reading comes
  // a full period plus one sense window after enable.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      period_q <= 32'h0;
    end else if (!battery_monitor_en) begin
      period_q <= 32'h0;
    end else if (period_q == 32'(BAT_PERIOD_CYC - 1)) begin
      period_q <= 32'h0;
    end else begin
      period_q <= period_q + 32'h1;
    end
  end

  assign bat_tick = battery_monitor_en
                    && (period_q == 32'(BAT_PERIOD_CYC - 1));

  duration_timer #(
    .CYCLES (BAT_ON_CYC)
  ) u_bat_timer (
    .core_clk (core_clk),
    .nrst     (nrst),
    .start    (bat_tick),
    .busy     (bat_busy),
    .done     (bat_done)
  );

  assign battery_sense_power = bat_busy && battery_monitor_en;
  assign rc_osc_en           = battery_monitor_en && sleep_mode;

  // One reading is taken at the end of each sense window.
  assign bat_reading = bat_done && battery_monitor_en;

  // Level code is taken from the sensing converter at window end.
  // It keeps the last reading while the monitor is off.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      level_q <= 5'h00;
    end else if (bat_reading) begin
      level_q <= battery_raw_code;
    end
  end

  assign bat_low = battery_raw_code < threshold_q;

  low_reading_filter #(
    .NEED (LOW_READINGS)
  ) u_low_filter (
    .core_clk      (core_clk),
    .nrst          (nrst),
    .reading_valid (bat_reading),
    .reading_low   (bat_low),
    .trigger       (bat_trigger)
  );

  assign battery_low_event = bat_trigger;

  // ===========================================================================
  // Interrupt pending flag
  // A new event in the same cycle as an acknowledge keeps the flag set.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pend_q <= 1'b0;
    end else if (bat_trigger) begin
      pend_q <= 1'b1;
    end else if (battery_irq_ack) begin
      pend_q <= 1'b0;
    end
  end

  assign interrupt_out_n = !(pend_q && battery_irq_en);

  // ===========================================================================
  // Read decode
  // Unmapped addresses read as zero.
  always_comb begin
    rd_data_d = 8'h00;
    if (reg_addr == ADDR_CONV_CONFIG) begin
      rd_data_d = {conv_busy, input_sel_q, ref_sel_q, gain_q};
    end else if (reg_addr == ADDR_SENSOR_OFFSET) begin
      rd_data_d = {4'h0, soffs_q};
    end else if (reg_addr == ADDR_CONV_RESULT) begin
      rd_data_d = result_q;
    end else if (reg_addr == ADDR_THERMAL_CTRL) begin
      rd_data_d = tsc_q;
    end else if (reg_addr == ADDR_THERMAL_OFFS) begin
      rd_data_d = tvoffs_q;
    end else if (reg_addr == ADDR_BAT_THRESHOLD) begin
      rd_data_d = {3'h0, threshold_q};
    end else if (reg_addr == ADDR_BAT_LEVEL) begin
      rd_data_d = {3'h0, level_q};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rd_data_q <= 8'h00;
    end else if (reg_rd_en) begin
      rd_data_q <= rd_data_d;
    end
  end

  assign reg_rd_data = rd_data_q;

endmodule : aux_monitor
`default_nettype wire

// [aux_monitor_pkg.sv]
// Constants shared by the auxiliary converter and battery monitor logic.
package aux_monitor_pkg;

  // ===========================================================================
  // Register addresses
  localparam logic [6:0] ADDR_CONV_CONFIG   = 7'h0f;
  localparam logic [6:0] ADDR_SENSOR_OFFSET = 7'h10;
  localparam logic [6:0] ADDR_CONV_RESULT   = 7'h11;
  localparam logic [6:0] ADDR_THERMAL_CTRL  = 7'h12;
  localparam logic [6:0] ADDR_THERMAL_OFFS  = 7'h13;
  localparam logic [6:0] ADDR_BAT_THRESHOLD = 7'h1a;
  localparam logic [6:0] ADDR_BAT_LEVEL     = 7'h1b;

  // ===========================================================================
  // Field positions
  localparam int unsigned CFG_GO_BIT      = 7;
  localparam int unsigned CFG_INPUT_LSB   = 4;
  localparam int unsigned CFG_REF_LSB     = 2;
  localparam int unsigned CFG_GAIN_LSB    = 0;
  localparam int unsigned TSC_RANGE_LSB   = 6;
  localparam int unsigned TSC_DIGOFFS_BIT = 5;
  localparam int unsigned TSC_ATRIM_BIT   = 4;
  localparam int unsigned TSC_TRIM_LSB    = 2;
  localparam int unsigned TSC_BGTRIM_LSB  = 0;

  // ===========================================================================
  // Reset values and codes
  localparam logic [6:0] CFG_RESET          = 7'h00;
  localparam logic [3:0] SENSOR_OFFS_RESET  = 4'h0;
  localparam logic [7:0] THERMAL_CTRL_RESET = 8'h20;
  localparam logic [7:0] THERMAL_OFFS_RESET = 8'h00;
  localparam logic [4:0] BAT_THRESH_RESET   = 5'h14;
  localparam logic [2:0] INPUT_TEMP_SENSOR  = 3'h0;
  localparam logic [7:0] RESULT_MAX         = 8'hff;

  // ===========================================================================
  // Timing
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned CONV_TIME_US   = 350;
  localparam int unsigned BAT_PERIOD_MS  = 1000;
  localparam int unsigned BAT_ON_TIME_US = 250;
  localparam int unsigned CONV_CYCLES    = CONV_TIME_US * CLK_MHZ;
  localparam int unsigned BAT_PERIOD_CYCLES = BAT_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int unsigned BAT_ON_CYCLES  = BAT_ON_TIME_US * CLK_MHZ;
  localparam int unsigned LOW_READINGS   = 4;

endpackage : aux_monitor_pkg

// [duration_timer.sv]
// One-shot timer that stays busy for a fixed number of clock cycles.
`timescale 1ns/100ps
`default_nettype none
module duration_timer #(
  parameter int unsigned CYCLES = 1
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  logic [31:0] cnt_q;
  logic        busy_q;

  // A start while busy is ignored.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      cnt_q  <= 32'h0;
    end else if (start && !busy_q) begin
      busy_q <= 1'b1;
      cnt_q  <= 32'(CYCLES - 1);
    end else if (busy_q) begin
      if (cnt_q == 32'h0) begin
        busy_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 32'h1;
      end
    end
  end

  assign busy = busy_q;
  assign done = busy_q && (cnt_q == 32'h0);

endmodule : duration_timer
`default_nettype wire

// [low_reading_filter.sv]
// Counts consecutive low battery readings and flags a run of the set length.
`timescale 1ns/100ps
`default_nettype none
module low_reading_filter #(
  parameter int unsigned NEED = 4
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic reading_valid,
  input  wire logic reading_low,
  output logic      trigger
);

  logic [3:0] run_q;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      run_q <= 4'h0;
    end else if (reading_valid) begin
      if (!reading_low) begin
        run_q <= 4'h0;
      end else if (run_q != 4'(NEED)) begin
        run_q <= run_q + 4'h1;
      end
    end
  end

  assign trigger = reading_valid && reading_low && (run_q == 4'(NEED - 1));

endmodule : low_reading_filter
`default_nettype wire

// [aux_monitor_props.sv]
// Concurrent checks on the auxiliary monitor ports.
`timescale 1ns/100ps
`default_nettype none
module aux_monitor_props
  import aux_monitor_pkg::*;
#(
  parameter int unsigned CONV_CYC   = 20,
  parameter int unsigned BAT_ON_CYC = 5
) (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic [6:0] reg_addr,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic       conv_active,
  input wire logic [2:0] conv_input_sel,
  input wire logic       temp_on_test_bus,
  input wire logic       temp_sensor_power,
  input wire logic       battery_monitor_en,
  input wire logic       sleep_mode,
  input wire logic       battery_irq_en,
  input wire logic       battery_sense_power,
  input wire logic       rc_osc_en,
  input wire logic       battery_low_event,
  input wire logic       interrupt_out_n
);
  // ===========================================================================
  // Helpers
  localparam int LAST = CONV_CYC - 1;
  localparam int ON_MAX = BAT_ON_CYC;
  logic go_w;
  logic busy_rd_w;
  logic lvl_rd_w;
  assign go_w = reg_wr_en && reg_addr == ADDR_CONV_CONFIG && reg_wr_data[7];
  assign busy_rd_w = reg_rd_en && reg_addr == ADDR_CONV_CONFIG && conv_active;
  assign lvl_rd_w = reg_rd_en && reg_addr == ADDR_BAT_LEVEL;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ===========================================================================
  // Assertions
  go_start_a: assert property (go_w && !conv_active |=> conv_active)
    else $error("go write did not start a conversion");
  conv_len_a: assert property ($rose(conv_active) |->
    ##LAST conv_active ##1 !conv_active)
    else $error("conversion length wrong");
  busy_read_a: assert property ($past(busy_rd_w) |-> reg_rd_data[7])
    else $error("busy flag not read back");
  sensor_pwr_a: assert property (temp_sensor_power ==
    (conv_input_sel == INPUT_TEMP_SENSOR || temp_on_test_bus))
    else $error("sensor power wrong");
  rc_osc_a: assert property (
    rc_osc_en == (battery_monitor_en && sleep_mode))
    else $error("rc oscillator enable wrong");
  irq_mask_a: assert property (!battery_irq_en && !$past(battery_irq_en)
    |-> interrupt_out_n)
    else $error("interrupt while disabled");
  low_irq_a: assert property (battery_low_event && battery_irq_en
    |=> !interrupt_out_n)
    else $error("low event gave no interrupt");
  sense_win_a: assert property ($rose(battery_sense_power) |->
    battery_sense_power[*4] ##[1:ON_MAX] !battery_sense_power)
    else $error("sense window wrong");
  level_top_a: assert property ($past(lvl_rd_w) |->
    reg_rd_data[7:5] == 3'h0)
    else $error("level upper bits set");
  go_c: cover property (go_w);
  done_c: cover property ($fell(conv_active));
  event_c: cover property (battery_low_event);
endmodule : aux_monitor_props
bind aux_monitor aux_monitor_props #(.CONV_CYC(CONV_CYC),
  .BAT_ON_CYC(BAT_ON_CYC)) chk (.core_clk(core_clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
  .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
  .conv_active(conv_active), .conv_input_sel(conv_input_sel),
  .temp_on_test_bus(temp_on_test_bus), .temp_sensor_power(temp_sensor_power),
  .battery_monitor_en(battery_monitor_en), .sleep_mode(sleep_mode),
  .battery_irq_en(battery_irq_en), .battery_sense_power(battery_sense_power),
  .rc_osc_en(rc_osc_en), .battery_low_event(battery_low_event),
  .interrupt_out_n(interrupt_out_n));
`default_nettype wire

// [host_port_model.sv]
// Host side register access model for the auxiliary monitor.
`timescale 1ns/100ps
`default_nettype none
module host_port_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rd_data,
  output logic      [6:0] reg_addr,
  output logic            reg_wr_en,
  output logic      [7:0] reg_wr_data,
  output logic            reg_rd_en,
  output logic            battery_irq_ack
);
  initial begin
    reg_addr = 7'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
    battery_irq_ack = 1'b0;
  end
  // Each conversion needs its own write of the go bit.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    reg_wr_data <= ~d;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    @(negedge core_clk);
    d = reg_rd_data;
  endtask : rd
  task automatic ack();
    @(posedge core_clk);
    battery_irq_ack <= 1'b1;
    @(posedge core_clk);
    battery_irq_ack <= 1'b0;
  endtask : ack
endmodule : host_port_model
`default_nettype wire

// [tb_aux_monitor.sv]
// Self-checking bench for the auxiliary monitor.
`timescale 1ns/100ps
`default_nettype none
module tb_aux_monitor;
  import aux_monitor_pkg::*;
  logic core_clk, nrst, reg_wr_en, reg_rd_en, battery_irq_ack, conv_active;
  logic temp_on_test_bus, relative_temp_mode, temp_sensor_power;
  logic temp_relative_out, analog_trim_en, battery_monitor_en, sleep_mode;
  logic battery_irq_en, battery_sense_power, rc_osc_en, battery_low_event;
  logic interrupt_out_n;
  logic [6:0] reg_addr;
  logic [7:0] reg_wr_data, reg_rd_data, conv_raw_code, d;
  logic [4:0] battery_raw_code, thr;
  logic [3:0] supply_offset_trim;
  logic [2:0] conv_input_sel;
  logic [1:0] conv_ref_sel, bridge_amp_gain, thermal_range_sel;
  logic [1:0] analog_temp_trim, bandgap_trim;
  logic [31:0] seed = 32'h00000060;
  logic [31:0] v;
  int fails = 0, comparisons = 0, ev = 0, exp_ev, cnt, e, n;
  logic [6:0] ra [6] = '{7'h0f, 7'h10, 7'h12, 7'h13, 7'h1a, 7'h05};
  logic [7:0] re [6] = '{8'h00, 8'h00, 8'h20, 8'h00, 8'h14, 8'h00};
  aux_monitor #(.CONV_CYC(20), .BAT_PERIOD_CYC(50), .BAT_ON_CYC(5)) uut (.*);
  host_port_model host (.*);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (battery_low_event === 1'b1) ev++;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic wait_sense(input logic lvl);
    n = 0;
    while (battery_sense_power !== lvl && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 200) begin
      fails++;
      $display("mismatch at %0t: sense window wait timed out", $time);
    end
  endtask : wait_sense
  initial begin
    #200us;
    fails++;
    summarize();
  end
  initial begin
    nrst = 1'b0;
    {conv_raw_code, battery_raw_code, temp_on_test_bus} = '0;
    {relative_temp_mode, battery_monitor_en, sleep_mode, battery_irq_en} = '0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      host.rd(ra[i], d);
      chk(d, re[i]);
    end
    $display("test reset values done");
    v = rnd();
    host.wr(ADDR_CONV_CONFIG, {1'b0, v[6:0]});
    host.wr(ADDR_SENSOR_OFFSET, v[15:8]);
    @(negedge core_clk);
    chk({1'b0, conv_input_sel, conv_ref_sel, bridge_amp_gain},
        {1'b0, v[6:0]});
    chk({6'h0, temp_sensor_power, rc_osc_en},
        {6'h0, v[6:4] == 3'h0, 1'b0});
    chk({4'h0, supply_offset_trim}, {4'h0, v[11:8]});
    $display("test config fields done");
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      @(posedge core_clk);
      conv_raw_code <= v[7:0];
      temp_on_test_bus <= v[22];
      relative_temp_mode <= v[23];
      host.wr(ADDR_THERMAL_OFFS, v[15:8]);
      host.wr(ADDR_THERMAL_CTRL, {v[17:16], i[0], i[1], v[19:18], v[21:20]});
      host.wr(ADDR_CONV_CONFIG, 8'h80);
      host.rd(ADDR_CONV_CONFIG, d);
      chk({7'h0, d[7]}, 8'h01);
      chk({temp_relative_out, thermal_range_sel, analog_trim_en,
           analog_temp_trim, bandgap_trim}, {v[23], v[17:16], i[1],
           i[1] ? v[19:18] : 2'b0, v[21:20]});
      chk({7'h0, temp_sensor_power}, 8'h01);
      host.wr(ADDR_CONV_CONFIG, 8'h80);
      host.wr(ADDR_CONV_RESULT, ~v[7:0]);
      n = 0;
      while (conv_active !== 1'b0 && n < 100) begin
        @(negedge core_clk);
        n++;
      end
      if (n >= 100) begin
        fails++;
        $display("mismatch at %0t: conversion never ended", $time);
      end
      e = v[7:0] + (i[0] ? int'(v[15:8]) : 0);
      if (e > 255) e = 255;
      host.rd(ADDR_CONV_RESULT, d);
      chk(d, e[7:0]);
    end
    $display("test conversions done");
    thr = {1'b1, 4'(rnd())};
    host.wr(ADDR_BAT_THRESHOLD, {3'h7, thr});
    host.rd(ADDR_BAT_THRESHOLD, d);
    chk(d, {3'h0, thr});
    @(posedge core_clk);
    battery_raw_code <= thr - 5'h1;
    {battery_monitor_en, sleep_mode, battery_irq_en} <= 3'h7;
    exp_ev = 0;
    cnt = 0;
    for (int k = 0; k < 7; k++) begin
      wait_sense(1'b1);
      wait_sense(1'b0);
      e = battery_raw_code;
      cnt = (k == 2) ? 0 : cnt + 1;
      if (cnt == 4) exp_ev++;
      battery_raw_code <= (k == 1) ? thr : thr - 5'h1;
      repeat (2) @(posedge core_clk);
      chk(ev[7:0], exp_ev[7:0]);
      chk({7'h0, interrupt_out_n}, exp_ev ? 8'h00 : 8'h01);
      host.rd(ADDR_BAT_LEVEL, d);
      chk(d, e[7:0]);
    end
    host.ack();
    @(negedge core_clk);
    chk({7'h0, interrupt_out_n}, 8'h01);
    chk({7'h0, rc_osc_en}, 8'h01);
    @(posedge core_clk);
    {battery_monitor_en, sleep_mode, battery_irq_en} <= 3'h0;
    $display("test battery monitor done");
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    host.rd(ADDR_BAT_THRESHOLD, d);
    chk(d, {3'h0, BAT_THRESH_RESET});
    $display("test mid-run reset done");
    summarize();
  end
endmodule : tb_aux_monitor
`default_nettype wire
